// file: core/xbus_consts.svh
// Constants for the repeater expansion bus port
// Overview of operation
// - Port has data and status two-way lines, grant and contention inputs, request output.
// - All chips run from one common clock.
// - Up to three chips share the lines without transceivers.
// - Repeated data on the data line is NRZ and clock synchronous.
// - Active chip drives status high while jamming after a collision.
// - While status is high, data high means collision on one port only.
// - Runt or fragment: one-port-left shown one bus cycle before request release.
// - Active-low request asserted while active and needing the shared lines.
// - Asserted contention input is treated as a multi-chip collision.
// - Transition cycle: grant on, contention off, lines undriven, chips keep jamming.
// - Afterwards the remaining requester drives as master with collision.
// - In reset active-low outputs high, active-high low, two-way pins undriven.
`ifndef XBUS_CONSTS_SVH
`define XBUS_CONSTS_SVH
`define XBUS_CLK_PERIOD_NS 20
`define XBUS_BUS_CYCLE_NS  100
`define XBUS_BUS_CYCLES    ((`XBUS_BUS_CYCLE_NS + `XBUS_CLK_PERIOD_NS - 1) / `XBUS_CLK_PERIOD_NS)
`define XBUS_CNT_W         3
`endif

// file: core/xbus_pkg.sv
// Types for the repeater expansion bus port
package xbus_pkg;
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_DRIVE  = 5'b00010,
      ST_FRAG   = 5'b00100,
      ST_CONTEND = 5'b01000,
      ST_TRANS  = 5'b10000
   } xstate_e;
endpackage

// file: core/xbus_port.sv
// Repeater expansion port: request, arbitration response and line driving
`timescale 1ns/1ps
`default_nettype none
`include "xbus_consts.svh"
module xbus_port (
   input  wire logic CLOCK,
   input  wire logic SYS_RST,
   input  wire logic ACTIVE,
   input  wire logic RUNT,
   input  wire logic REPEAT_DATA,
   input  wire logic LOCAL_COLLISION,
   input  wire logic ONE_PORT_COLLISION,
   input  wire logic EXPANSION_DATA_LINE_IN,
   output logic      EXPANSION_DATA_LINE_OUT,
   output logic      EXPANSION_DATA_LINE_OE,
   input  wire logic JAM_STATUS_IN,
   output logic      JAM_STATUS_OUT,
   output logic      JAM_STATUS_OE,
   input  wire logic GRANT_N,
   input  wire logic MULTI_REQ_N,
   output logic      REQUEST_N,
   output logic      COLLISION,
   output logic      SLAVE_DATA,
   output logic      SLAVE_JAM,
   output logic      SLAVE_ONE_PORT
);
   import xbus_pkg::*;

   xstate_e state;
   xstate_e next_state;
   logic    drive;
   logic    grant;
   logic    multi;
   logic    jam_hold;
   xbus_tick_if tk();

   // Port of five lines; all chips share CLOCK
   assign grant = !GRANT_N;
   assign multi = !MULTI_REQ_N;
   // Restart also on fragment and transition entry, so each lasts exactly one bus cycle
   assign tk.restart = ((state == ST_IDLE) && ACTIVE)
                    || ((state == ST_DRIVE) && !multi && RUNT)
                    || ((state == ST_CONTEND) && ACTIVE && grant && !multi);

   xbus_tick #(.CYCLES(`XBUS_BUS_CYCLES)) u_tick (
      .clk (CLOCK),
      .rst (SYS_RST),
      .tk  (tk)
   );

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
            if (ACTIVE)
               next_state = ST_DRIVE;
         ST_DRIVE:
            if (multi)
               next_state = ST_CONTEND;
            else if (RUNT)
               next_state = ST_FRAG;
            else if (!ACTIVE)
               next_state = ST_IDLE;
         ST_FRAG:
            if (tk.tick)
               next_state = ST_IDLE;
         ST_CONTEND:
            if (!ACTIVE)
               next_state = ST_IDLE;
            else if (grant && !multi)
               next_state = ST_TRANS;
         ST_TRANS:
            if (tk.tick)
               next_state = ACTIVE ? ST_DRIVE : ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Collision from contention persists until the request drops
   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST || state == ST_IDLE)
         jam_hold <= 1'b0;
      else if (multi)
         jam_hold <= 1'b1;
   end

   // Drive only when sole granted owner; lines float otherwise, so
   // three chips may share them directly
   assign drive = grant && !multi && (state == ST_DRIVE || state == ST_FRAG);

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         EXPANSION_DATA_LINE_OE <= 1'b0;
         JAM_STATUS_OE <= 1'b0;
         EXPANSION_DATA_LINE_OUT <= 1'b0;
         JAM_STATUS_OUT <= 1'b0;
      end
      else
      begin
         EXPANSION_DATA_LINE_OE <= drive;
         JAM_STATUS_OE <= drive;
         if (state == ST_FRAG)
         begin
            JAM_STATUS_OUT <= 1'b1;
            EXPANSION_DATA_LINE_OUT <= 1'b1;
         end
         else if (LOCAL_COLLISION || jam_hold)
         begin
            JAM_STATUS_OUT <= 1'b1;
            EXPANSION_DATA_LINE_OUT <= ONE_PORT_COLLISION && !jam_hold;
         end
         else
         begin
            JAM_STATUS_OUT <= 1'b0;
            EXPANSION_DATA_LINE_OUT <= REPEAT_DATA;
         end
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
         REQUEST_N <= 1'b1;
      else
         // Held through the last fragment cycle so the signalling fills a whole bus cycle
         REQUEST_N <= !((next_state != ST_IDLE) || (state == ST_FRAG));
   end

   always_ff @(posedge CLOCK)
   begin
      if (SYS_RST)
      begin
         COLLISION <= 1'b0;
         SLAVE_DATA <= 1'b0;
         SLAVE_JAM <= 1'b0;
         SLAVE_ONE_PORT <= 1'b0;
      end
      else
      begin
         COLLISION <= multi || jam_hold || state == ST_CONTEND || state == ST_TRANS;
         SLAVE_DATA <= EXPANSION_DATA_LINE_IN;
         SLAVE_JAM <= JAM_STATUS_IN;
         SLAVE_ONE_PORT <= JAM_STATUS_IN && EXPANSION_DATA_LINE_IN;
      end
   end

   req_reset_a: assert property (@(posedge CLOCK)
      SYS_RST |=> REQUEST_N && !EXPANSION_DATA_LINE_OE && !JAM_STATUS_OE)
      else $error("outputs not idle after reset");
   no_drive_multi_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      multi |=> !EXPANSION_DATA_LINE_OE)
      else $error("driving during contention");
   contend_coll_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      multi |=> COLLISION)
      else $error("contention not taken as collision");
   req_active_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state == ST_IDLE && ACTIVE) |=> !REQUEST_N)
      else $error("request missing");
   frag_one_port_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state == ST_FRAG) |=> JAM_STATUS_OUT && EXPANSION_DATA_LINE_OUT)
      else $error("fragment not signalled one-port-left");
   frag_len_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state == ST_DRIVE && next_state == ST_FRAG) |=> !REQUEST_N [*6])
      else $error("fragment request released early");
   jam_status_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (LOCAL_COLLISION && state == ST_DRIVE) |=> JAM_STATUS_OUT)
      else $error("status not high on collision");
   trans_jam_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (state == ST_TRANS) |=> COLLISION)
      else $error("collision dropped in transition");

   cov_drive_c: cover property (@(posedge CLOCK) state == ST_DRIVE && drive);
   cov_frag_c: cover property (@(posedge CLOCK) state == ST_FRAG);
   cov_trans_c: cover property (@(posedge CLOCK) state == ST_TRANS ##1 state == ST_DRIVE);
endmodule
`default_nettype wire

// file: core/xbus_tick.sv
// Bus cycle timer: pulses once per expansion bus cycle
`timescale 1ns/1ps
`default_nettype none
`include "xbus_consts.svh"
module xbus_tick #(
   parameter int CYCLES = `XBUS_BUS_CYCLES
) (
   input  wire logic   clk,
   input  wire logic   rst,
   xbus_tick_if.timer  tk
);
   logic [`XBUS_CNT_W-1:0] cnt;

   // Restart aligns bus cycles to the start of arbitration
   always_ff @(posedge clk)
   begin
      if (rst || tk.restart || cnt == `XBUS_CNT_W'(CYCLES - 1))
         cnt <= '0;
      else
         cnt <= cnt + 1'b1;
   end

   assign tk.tick = (cnt == `XBUS_CNT_W'(CYCLES - 1)) && !tk.restart;

   tick_period_a: assert property (@(posedge clk) disable iff (rst)
      tk.tick |=> !tk.tick [*4]) else $error("bus cycle tick too frequent");
endmodule
`default_nettype wire

// file: core/xbus_tick_if.sv
// Bus cycle tick shared between the expansion port and its timer
`timescale 1ns/1ps
`default_nettype none
interface xbus_tick_if;
   logic restart;
   logic tick;
   modport timer (input restart, output tick);
   modport user  (output restart, input tick);
endinterface
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the expansion port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, rst = 1, active = 0, runt = 0, rdata = 0, lcol = 0, onep = 0;
   logic other_n = 1, pat = 0;
   logic dat_out, dat_oe, jam_out, jam_oe, req_n, grant_n, multi_n, coll;
   logic sdat, sjam, sone, prevd, bpg_n, bpc_n, dir;
   wire  dat, jam;
   int   seed = 9, n_mismatch = 0, samples_checked = 0, cycles = 0, i, cnt;
   // Released lines show a toggling pattern, never the last driven value
   assign dat = dat_oe ? dat_out : pat;
   assign jam = jam_oe ? jam_out : ~pat;
   initial forever #10 clk = ~clk;
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      pat <= ~pat;
      if (cycles == 3000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   xbus_port i_dut (.CLOCK(clk), .SYS_RST(rst), .ACTIVE(active), .RUNT(runt),
      .REPEAT_DATA(rdata), .LOCAL_COLLISION(lcol), .ONE_PORT_COLLISION(onep),
      .EXPANSION_DATA_LINE_IN(dat), .EXPANSION_DATA_LINE_OUT(dat_out),
      .EXPANSION_DATA_LINE_OE(dat_oe), .JAM_STATUS_IN(jam), .JAM_STATUS_OUT(jam_out),
      .JAM_STATUS_OE(jam_oe), .GRANT_N(grant_n), .MULTI_REQ_N(multi_n),
      .REQUEST_N(req_n), .COLLISION(coll), .SLAVE_DATA(sdat), .SLAVE_JAM(sjam),
      .SLAVE_ONE_PORT(sone));
   // Second requester stands for another chip on the same bus
   xbus_arbiter_model #(.N(2)) i_arb (.req_n({other_n, req_n}), .grant_n(grant_n),
      .multi_req_n(multi_n), .bp_grant_n(bpg_n), .bp_cont_n(bpc_n), .dir(dir));
   // Modular arbitration must agree with the flat arbiter for a single module
   always @(negedge clk)
   begin
      if (!rst)
      begin
         check("bp grant", bpg_n, grant_n);
         check("bp contention", bpc_n, multi_n);
         check("direction", dir, !grant_n);
      end
   end
   task automatic check(input string name, input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #2;
   endtask
   task automatic test_done();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) step();
      check("req_n reset", req_n, 1'b1);
      check("data oe reset", dat_oe, 1'b0);
      check("status oe reset", jam_oe, 1'b0);
      rst = 0;
      step();
      active = 1;
      repeat (2) step();
      check("request", req_n, 1'b0);
      for (i = 0; i < 40; i++)
      begin
         prevd = rdata;
         rdata = 1'($random(seed));
         step();
         if (i > 2)
         begin
            check("data oe", dat_oe, 1'b1);
            check("nrz data", dat_out, rdata);
            check("status idle", jam_out, 1'b0);
            check("slave data", sdat, prevd);
            check("slave status", sjam, 1'b0);
         end
      end
      for (i = 0; i < 8; i++)
      begin
         lcol = 1;
         onep = (i < 2) ? i[0] : 1'($random(seed));
         repeat (2) step();
         check("jam status", jam_out, 1'b1);
         check("one port", dat_out, onep);
         check("slave one port", sone, onep);
      end
      lcol = 0;
      step();
      runt = 1;
      step();
      runt = 0;
      active = 0;
      // Fragment: one bus cycle of one-port-left before the request drops
      for (i = 0; i < 5; i++)
      begin
         step();
         check("frag status", jam_out, 1'b1);
         check("frag data", dat_out, 1'b1);
         check("frag req", req_n, 1'b0);
      end
      step();
      check("frag release", req_n, 1'b1);
      active = 0;
      repeat (3) step();
      active = 1;
      other_n = 0;
      repeat (4) step();
      check("contention", coll, 1'b1);
      check("no drive", dat_oe, 1'b0);
      other_n = 1;
      cnt = 0;
      while (dat_oe !== 1'b1 && cnt < 20)
      begin
         check("jam held", coll, 1'b1);
         step();
         cnt++;
      end
      // One edge to enter, one bus cycle of transition, one edge to drive
      check("transition", cnt == 7, 1'b1);
      check("master status", jam_out, 1'b1);
      check("master data", dat_out, 1'b0);
      active = 0;
      repeat (3) step();
      check("release", req_n, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire

// file: verif/xbus_arbiter_model.sv
// Behavioural expansion bus arbiter facing several chips
`timescale 1ns/1ps
`default_nettype none
module xbus_arbiter_model #(
   parameter int N = 2
) (
   input  wire logic [N-1:0] req_n,
   output logic              grant_n,
   output logic              multi_req_n,
   output logic              bp_grant_n,
   output logic              bp_cont_n,
   output logic              dir
);
   logic [N-1:0] req;
   logic         mod_req;
   logic         mod_col;
   logic         bp_grant;
   logic         bp_cont;
   assign req = ~req_n;
   // Combinational, so every chip sees one consistent state in the same cycle
   assign grant_n     = !($countones(req) == 1);
   assign multi_req_n = !(grant_n && (|req));
   // Two-level path: these chips form one module, a second module stays idle
   assign mod_req    = ($countones(req) == 1);
   assign mod_col    = !mod_req && (|req);
   assign bp_grant   = !mod_col && mod_req;
   assign bp_cont    = (!bp_grant && mod_req) || mod_col;
   assign dir        = mod_req && bp_grant;
   assign bp_grant_n = !bp_grant;
   assign bp_cont_n  = !bp_cont;
endmodule
`default_nettype wire
